// File: rtl/svn_regs.svh
// Register map, field positions and reset values of the serial vector number registers.
// Included by the top design file, which decodes the offsets, and by the bench.
`ifndef SVN_REGS_SVH
`define SVN_REGS_SVH

`define SVN_OFF_CH1_ERR      8'h00
`define SVN_OFF_CH1_DATA     8'h04
`define SVN_OFF_CH2_ERR      8'h08
`define SVN_OFF_CH2_DATA     8'h0c
`define SVN_OFF_VBR          8'h10
`define SVN_HI_MSB           14
`define SVN_HI_LSB           8
`define SVN_LO_MSB           6
`define SVN_LO_LSB           0
`define SVN_REG_RESET        16'h0000
`define SVN_VBR_RESET        32'h0000_0000
`define SVN_WRITE_MASK       16'h7f7f
`define SVN_ENTRY_SHIFT      2

`endif

// File: rtl/svn_pkg.sv
// Types shared by the serial vector number block.
// Assumes the register header is on the include path.
package svn_pkg;

   // The eight serial-channel interrupt sources, in register field order.
   typedef enum logic [2:0] {
      SVN_CH1_RX_OVERRUN,
      SVN_CH1_TX_UNDERRUN,
      SVN_CH1_RX_FULL,
      SVN_CH1_TX_EMPTY,
      SVN_CH2_RX_OVERRUN,
      SVN_CH2_TX_UNDERRUN,
      SVN_CH2_RX_FULL,
      SVN_CH2_TX_EMPTY
   } svn_src_t;

   typedef logic [6:0] svn_vec_t;

   typedef enum logic [1:0] {
      SVN_AXI_OKAY   = 2'b00,
      SVN_AXI_SLVERR = 2'b10
   } svn_resp_t;

endpackage

// File: rtl/svn_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight; a read answers one cycle after it is taken.
// Assumes a register file on the same clock that takes a one-cycle write strobe and a combinational read.
`timescale 1ns/10ps
module svn_axil_slave
   import svn_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input  wire logic                i_clock,
   input  wire logic                i_rstn,
   // Write address and data channels.
   input  wire logic [ADDR_W-1:0]   i_awaddr,
   input  wire logic                i_awvalid,
   output logic                     o_awready,
   input  wire logic [31:0]         i_wdata,
   input  wire logic [3:0]          i_wstrb,
   input  wire logic                i_wvalid,
   output logic                     o_wready,
   // Write response channel.
   output logic [1:0]               o_bresp,
   output logic                     o_bvalid,
   input  wire logic                i_bready,
   // Read channels.
   input  wire logic [ADDR_W-1:0]   i_araddr,
   input  wire logic                i_arvalid,
   output logic                     o_arready,
   output logic [31:0]              o_rdata,
   output logic [1:0]               o_rresp,
   output logic                     o_rvalid,
   input  wire logic                i_rready,
   // Register file side.
   output logic                     o_wr_en,
   output logic [ADDR_W-1:0]        o_wr_addr,
   output logic [31:0]              o_wr_data,
   output logic [3:0]               o_wr_strb,
   input  wire logic                i_wr_ok,
   output logic [ADDR_W-1:0]        o_rd_addr,
   input  wire logic [31:0]         i_rd_data,
   input  wire logic                i_rd_ok
);

   if (ADDR_W < 5) begin : g_chk_addr_w
      $error("ADDR_W too small for the register map");
   end

   logic                aw_hold_ff;
   logic [ADDR_W-1:0]   aw_addr_ff;
   logic                w_hold_ff;
   logic [31:0]         w_data_ff;
   logic [3:0]          w_strb_ff;
   logic                bvalid_ff;
   logic [1:0]          bresp_ff;
   logic                rvalid_ff;
   logic [1:0]          rresp_ff;
   logic [31:0]         rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Write path: address and data are caught in either order, then committed together.
   assign o_awready = !aw_hold_ff && !bvalid_ff;
   assign o_wready  = !w_hold_ff && !bvalid_ff;
   assign o_wr_en   = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign o_wr_addr = aw_addr_ff;
   assign o_wr_data = w_data_ff;
   assign o_wr_strb = w_strb_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         aw_hold_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (o_awready && i_awvalid) begin
         aw_hold_ff <= 1'b1;
         aw_addr_ff <= i_awaddr;
      end else if (o_wr_en) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         w_hold_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end else if (o_wready && i_wvalid) begin
         w_hold_ff <= 1'b1;
         w_data_ff <= i_wdata;
         w_strb_ff <= i_wstrb;
      end else if (o_wr_en) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= 2'b00;
      end else if (o_wr_en) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= i_wr_ok ? SVN_AXI_OKAY : SVN_AXI_SLVERR;
      end else if (bvalid_ff && i_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: the register file answers combinationally, so data is latched at acceptance.
   assign o_arready = !rvalid_ff;
   assign o_rd_addr = i_araddr;
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= 2'b00;
      end else if (o_arready && i_arvalid) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= i_rd_data;
         rresp_ff  <= i_rd_ok ? SVN_AXI_OKAY : SVN_AXI_SLVERR;
      end else if (rvalid_ff && i_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule

// File: rtl/svn_vector_select.sv
// Vector select: picks the field of the accepted source and forms the table entry address.
// Assumes the fields come straight from the register file on the same clock.
`timescale 1ns/10ps
module svn_vector_select
   import svn_pkg::*;
#(
   parameter int NSRC = 8
) (
   // Clock and reset.
   input  wire logic                 i_clock,
   input  wire logic                 i_rstn,
   // Fields and base.
   input  wire logic [NSRC*7-1:0]    i_fields,
   input  wire logic [31:0]          i_vbr,
   // Acceptance.
   input  wire logic                 i_accept,
   input  wire logic [2:0]           i_src,
   // Result.
   output logic                      o_valid,
   output logic [6:0]                o_vector,
   output logic [31:0]               o_entry_addr
);

   if (NSRC != 8) begin : g_chk_nsrc
      $error("NSRC must be 8: the source code is three bits");
   end

   logic [6:0] sel;
   logic       valid_ff;
   logic [6:0] vector_ff;
   logic [31:0] entry_ff;

   always_comb begin
      sel = i_fields[i_src*7 +: 7];
   end

   // The field is sampled at acceptance, so a rewrite afterwards does not disturb it.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         valid_ff  <= 1'b0;
         vector_ff <= '0;
         entry_ff  <= '0;
      end else begin
         valid_ff <= i_accept;
         if (i_accept) begin
            vector_ff <= sel; // [R15]
            entry_ff  <= i_vbr + {23'h000000, sel, 2'b00}; // [R14]
         end
      end
   end

   assign o_valid      = valid_ff;
   assign o_vector     = vector_ff;
   assign o_entry_addr = entry_ff;

   property p_entry_addr;
      @(posedge i_clock) disable iff (!i_rstn)
         i_accept |=> o_entry_addr == $past(i_vbr) + ({25'h0000000, $past(sel)} << 2);
   endproperty
   a_entry_addr: assert property (p_entry_addr) else $error("entry address is not base plus four times vector"); // [R14]

   property p_vector_out;
      @(posedge i_clock) disable iff (!i_rstn)
         i_accept |=> o_valid && o_vector == $past(i_fields[i_src*7 +: 7]);
   endproperty
   a_vector_out: assert property (p_vector_out) else $error("presented vector differs from the source field"); // [R15]

endmodule

// File: rtl/svn_top.sv
// Serial channel vector number registers with an AXI4-Lite slave and vector presentation.
// Assumes one 20 MHz clock, a synchronous acceptance strobe from the priority logic, and byte addressing.
//
// Notes on behaviour
// [R1] Four 16-bit read/write registers, two fields each.
// [R2] Reset clears all four registers to zero.
// [R3] Standby leaves register contents untouched.
// [R4] Bits 15 and 7 read zero; write zero.
// [R5] Each field is seven bits, values 0 to 127.
// [R6] Channel 1 error register high: receive overrun.
// [R7] Channel 1 error register low: transmit underrun.
// [R8] Channel 1 data register high: receive full.
// [R9] Channel 1 data register low: transmit empty.
// [R10] Channel 2 error register high: receive overrun.
// [R11] Channel 2 error register low: transmit underrun.
// [R12] Channel 2 data register high: receive full.
// [R13] Channel 2 data register low: transmit empty.
// [R14] Entry address is base plus vector times four.
// [R15] Accepted source presents its current field.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "svn_regs.svh"
module svn_top
   import svn_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int NREG   = 4
) (
   // Clock and reset.
   input  wire logic                i_clock,
   input  wire logic                i_rstn,
   // AXI4-Lite write channels.
   input  wire logic [ADDR_W-1:0]   i_awaddr,
   input  wire logic                i_awvalid,
   output logic                     o_awready,
   input  wire logic [31:0]         i_wdata,
   input  wire logic [3:0]          i_wstrb,
   input  wire logic                i_wvalid,
   output logic                     o_wready,
   output logic [1:0]               o_bresp,
   output logic                     o_bvalid,
   input  wire logic                i_bready,
   // AXI4-Lite read channels.
   input  wire logic [ADDR_W-1:0]   i_araddr,
   input  wire logic                i_arvalid,
   output logic                     o_arready,
   output logic [31:0]              o_rdata,
   output logic [1:0]               o_rresp,
   output logic                     o_rvalid,
   input  wire logic                i_rready,
   // Standby indication from the power controller.
   input  wire logic                i_standby,
   // Interrupt acceptance from the priority logic.
   input  wire logic                i_accept,
   input  wire logic [2:0]          i_accept_src,
   // Vector presented to the processor.
   output logic                     o_vector_valid,
   output logic [6:0]               o_vector,
   output logic [31:0]              o_entry_addr,
   // Per-source vector fields for the acceptance logic.
   output logic [6:0]               o_ch1_rx_overrun_vector,
   output logic [6:0]               o_ch1_tx_underrun_vector,
   output logic [6:0]               o_ch1_rx_full_vector,
   output logic [6:0]               o_ch1_tx_empty_vector,
   output logic [6:0]               o_ch2_rx_overrun_vector,
   output logic [6:0]               o_ch2_tx_underrun_vector,
   output logic [6:0]               o_ch2_rx_full_vector,
   output logic [6:0]               o_ch2_tx_empty_vector
);

   if (NREG != 4) begin : g_chk_nreg
      $error("NREG must be 4: the map holds four vector registers");
   end
   if (ADDR_W < 5) begin : g_chk_addr_w
      $error("ADDR_W too small for the register map");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus front end.
   logic                wr_en;
   logic [ADDR_W-1:0]   wr_addr;
   logic [31:0]         wr_data;
   logic [3:0]          wr_strb;
   logic                wr_ok;
   logic [ADDR_W-1:0]   rd_addr;
   logic [31:0]         rd_data;
   logic                rd_ok;

   svn_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
      .i_clock   (i_clock),
      .i_rstn    (i_rstn),
      .i_awaddr  (i_awaddr),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_wdata   (i_wdata),
      .i_wstrb   (i_wstrb),
      .i_wvalid  (i_wvalid),
      .o_wready  (o_wready),
      .o_bresp   (o_bresp),
      .o_bvalid  (o_bvalid),
      .i_bready  (i_bready),
      .i_araddr  (i_araddr),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .o_rdata   (o_rdata),
      .o_rresp   (o_rresp),
      .o_rvalid  (o_rvalid),
      .i_rready  (i_rready),
      .o_wr_en   (wr_en),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data),
      .o_wr_strb (wr_strb),
      .i_wr_ok   (wr_ok),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_ok   (rd_ok)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Vector registers. Index 0..3 maps to offsets 0x00..0x0c in order.
   logic [15:0] vreg_ff [NREG];
   logic [31:0] vbr_ff;
   logic [15:0] byte_mask;

   // Byte lanes 0 and 1 carry the 16-bit register; upper lanes are ignored.
   assign byte_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_vreg
         localparam logic [ADDR_W-1:0] OFF = ADDR_W'(gi * 4);
         logic [15:0] nxt_vreg;
         always_comb begin
            // Reserved bits 15 and 7 are never stored, so they always read zero.
            nxt_vreg = (vreg_ff[gi] & ~byte_mask) | (wr_data[15:0] & byte_mask); // [R1]
            nxt_vreg = nxt_vreg & `SVN_WRITE_MASK; // [R4] [R5]
         end
         // Standby has no path into this flop; only reset and a bus write change it.
         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               vreg_ff[gi] <= `SVN_REG_RESET; // [R2]
            end else if (wr_en && wr_addr == OFF) begin
               vreg_ff[gi] <= nxt_vreg; // [R3]
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         vbr_ff <= `SVN_VBR_RESET;
      end else if (wr_en && wr_addr == `SVN_OFF_VBR) begin
         for (int b = 0; b < 4; b++) begin
            if (wr_strb[b]) vbr_ff[b*8 +: 8] <= wr_data[b*8 +: 8];
         end
      end
   end

   assign wr_ok = (wr_addr <= `SVN_OFF_VBR) && (wr_addr[1:0] == 2'b00);
   assign rd_ok = (rd_addr <= `SVN_OFF_VBR) && (rd_addr[1:0] == 2'b00);

   always_comb begin
      rd_data = 32'h0000_0000;
      if (rd_ok) begin
         if (rd_addr == `SVN_OFF_VBR) begin
            rd_data = vbr_ff;
         end else begin
            rd_data = {16'h0000, vreg_ff[rd_addr[3:2]]}; // [R1]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field breakout for each source.
   assign o_ch1_rx_overrun_vector  = vreg_ff[0][`SVN_HI_MSB:`SVN_HI_LSB]; // [R6]
   assign o_ch1_tx_underrun_vector = vreg_ff[0][`SVN_LO_MSB:`SVN_LO_LSB]; // [R7]
   assign o_ch1_rx_full_vector     = vreg_ff[1][`SVN_HI_MSB:`SVN_HI_LSB]; // [R8]
   assign o_ch1_tx_empty_vector    = vreg_ff[1][`SVN_LO_MSB:`SVN_LO_LSB]; // [R9]
   assign o_ch2_rx_overrun_vector  = vreg_ff[2][`SVN_HI_MSB:`SVN_HI_LSB]; // [R10]
   assign o_ch2_tx_underrun_vector = vreg_ff[2][`SVN_LO_MSB:`SVN_LO_LSB]; // [R11]
   assign o_ch2_rx_full_vector     = vreg_ff[3][`SVN_HI_MSB:`SVN_HI_LSB]; // [R12]
   assign o_ch2_tx_empty_vector    = vreg_ff[3][`SVN_LO_MSB:`SVN_LO_LSB]; // [R13]

   logic [55:0] fields;
   // Packed in source enum order, lowest source in the low bits.
   assign fields = {o_ch2_tx_empty_vector, o_ch2_rx_full_vector,
                    o_ch2_tx_underrun_vector, o_ch2_rx_overrun_vector,
                    o_ch1_tx_empty_vector, o_ch1_rx_full_vector,
                    o_ch1_tx_underrun_vector, o_ch1_rx_overrun_vector};

   svn_vector_select #(.NSRC(8)) u_sel (
      .i_clock      (i_clock),
      .i_rstn       (i_rstn),
      .i_fields     (fields),
      .i_vbr        (vbr_ff),
      .i_accept     (i_accept),
      .i_src        (i_accept_src),
      .o_valid      (o_vector_valid),
      .o_vector     (o_vector),
      .o_entry_addr (o_entry_addr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_write_reg0;
      wr_en && wr_addr == `SVN_OFF_CH1_ERR && wr_strb[1:0] == 2'b11;
   endsequence

   property p_write_lands;
      @(posedge i_clock) disable iff (!i_rstn)
         s_write_reg0 |=> vreg_ff[0] == ($past(wr_data[15:0]) & 16'h7f7f);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("register write did not land"); // [R1]

   // Checked at the edge after acceptance, so a master that holds rready low cannot confuse the address.
   property p_reserved_zero;
      @(posedge i_clock) disable iff (!i_rstn)
         o_arready && i_arvalid && rd_addr != `SVN_OFF_VBR |=> o_rdata[15] == 1'b0 && o_rdata[7] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one"); // [R4]

   property p_reset_clear;
      @(posedge i_clock) $rose(i_rstn) |-> vreg_ff[0] == 16'h0000 && vreg_ff[1] == 16'h0000
                                          && vreg_ff[2] == 16'h0000 && vreg_ff[3] == 16'h0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset"); // [R2]

   property p_standby_hold;
      @(posedge i_clock) disable iff (!i_rstn)
         $changed(i_standby) && !wr_en |=> $stable(vreg_ff[1]) && $stable(vreg_ff[3]);
   endproperty
   a_standby_hold: assert property (p_standby_hold) else $error("standby changed a vector register"); // [R3]

   property p_no_write_hold;
      @(posedge i_clock) disable iff (!i_rstn)
         !wr_en |=> $stable(vreg_ff[0]) && $stable(vreg_ff[2]);
   endproperty
   a_no_write_hold: assert property (p_no_write_hold) else $error("register changed without a write"); // [R3]

   property p_full_range;
      @(posedge i_clock) disable iff (!i_rstn)
         s_write_reg0 ##1 1'b1 |-> o_ch1_rx_overrun_vector == $past(wr_data[14:8]);
   endproperty
   a_full_range: assert property (p_full_range) else $error("seven-bit field not stored whole"); // [R5]

   property p_ch1_err_low;
      @(posedge i_clock) disable iff (!i_rstn)
         s_write_reg0 |=> o_ch1_tx_underrun_vector == $past(wr_data[6:0]);
   endproperty
   a_ch1_err_low: assert property (p_ch1_err_low) else $error("channel 1 underrun field wrong"); // [R7]

   property p_ch2_data_map;
      @(posedge i_clock) disable iff (!i_rstn)
         wr_en && wr_addr == `SVN_OFF_CH2_DATA && wr_strb[1:0] == 2'b11
         |=> o_ch2_rx_full_vector == $past(wr_data[14:8]) && o_ch2_tx_empty_vector == $past(wr_data[6:0]);
   endproperty
   a_ch2_data_map: assert property (p_ch2_data_map) else $error("channel 2 data fields misplaced"); // [R12]

   property p_answer_time;
      @(posedge i_clock) disable iff (!i_rstn)
         o_arready && i_arvalid |=> o_rvalid;
   endproperty
   a_answer_time: assert property (p_answer_time) else $error("read answer late");

endmodule

// File: verif/test_serial_io_vector_number_regs.sv
// Self-checking bench for the serial vector number registers, driven over AXI4-Lite.
// Assumes the design files, the package and the register header are compiled first.
`timescale 1ns/10ps
`include "svn_regs.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module test_serial_io_vector_number_regs
   import svn_pkg::*;
;
   logic              i_clock = 1'b0;
   logic              i_rstn;
   logic [7:0]        i_awaddr, i_araddr;
   logic              i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_standby, i_accept;
   logic [31:0]       i_wdata;
   logic [3:0]        i_wstrb;
   logic [2:0]        i_accept_src;
   logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_vector_valid;
   logic [1:0]        o_bresp, o_rresp;
   logic [31:0]       o_rdata, o_entry_addr;
   logic [6:0]        o_vector;
   logic [55:0]       fo_bus;
   logic [31:0]       mreg [5];
   logic              exp_pend;
   logic [6:0]        exp_vec;
   logic [31:0]       exp_entry;
   int                n_mismatch = 0;
   int                n_checks = 0;
   int                cyc = 0;

   always #25 i_clock = ~i_clock;

   svn_top svn_top_inst (
      .i_clock(i_clock), .i_rstn(i_rstn),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .i_standby(i_standby), .i_accept(i_accept), .i_accept_src(i_accept_src),
      .o_vector_valid(o_vector_valid), .o_vector(o_vector), .o_entry_addr(o_entry_addr),
      .o_ch1_rx_overrun_vector(fo_bus[6:0]), .o_ch1_tx_underrun_vector(fo_bus[13:7]),
      .o_ch1_rx_full_vector(fo_bus[20:14]), .o_ch1_tx_empty_vector(fo_bus[27:21]),
      .o_ch2_rx_overrun_vector(fo_bus[34:28]), .o_ch2_tx_underrun_vector(fo_bus[41:35]),
      .o_ch2_rx_full_vector(fo_bus[48:42]), .o_ch2_tx_empty_vector(fo_bus[55:49])
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] field_of(input int s);
      return s[0] ? mreg[s >> 1][6:0] : mreg[s >> 1][14:8];
   endfunction

   // The expected vector is captured at the accept edge, so it must appear exactly one cycle later.
   always @(posedge i_clock) begin
      exp_pend <= i_rstn && (i_accept === 1'b1);
      if (i_accept === 1'b1) begin
         exp_vec <= field_of(i_accept_src);
         exp_entry <= mreg[4] + {23'h0, field_of(i_accept_src), 2'b00};
      end
   end

   always @(negedge i_clock) begin
      if (i_rstn === 1'b1 && cyc > 7) begin
         `CHK("vector_valid", exp_pend, o_vector_valid)
         if (exp_pend) begin
            `CHK("vector", exp_vec, o_vector)
            `CHK("entry_addr", exp_entry, o_entry_addr)
         end
      end
   end

   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic ta, tw, ra, rw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge i_clock);
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= d;
      i_wstrb <= s;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge i_clock);
         ra = o_awready;
         rw = o_wready;
         @(posedge i_clock);
         if (ra === 1'b1 && !ta) begin
            i_awvalid <= 1'b0;
            ta = 1'b1;
         end
         if (rw === 1'b1 && !tw) begin
            i_wvalid <= 1'b0;
            tw = 1'b1;
         end
      end
      do @(negedge i_clock); while (o_bvalid !== 1'b1);
      r = o_bresp;
      @(posedge i_clock);
      i_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(negedge i_clock); while (o_arready !== 1'b1);
      @(posedge i_clock);
      i_arvalid <= 1'b0;
      do @(negedge i_clock); while (o_rvalid !== 1'b1);
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clock);
      i_rready <= 1'b0;
   endtask

   // Index 4 is the vector base; 0 to 3 are the vector registers in offset order.
   task automatic reg_write(input int idx, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axw(8'(idx * 4), d, s, r);
      `CHK("bresp", 2'(SVN_AXI_OKAY), r)
      for (int l = 0; l < 4; l++) begin
         if (s[l] && (idx == 4 || l < 2)) begin
            mreg[idx][8*l +: 8] = (idx == 4) ? d[8*l +: 8] : (d[8*l +: 8] & 8'h7f);
         end
      end
   endtask

   task automatic check_all();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 5; i++) begin
         axr(8'(i * 4), d, r);
         `CHK("rresp", 2'(SVN_AXI_OKAY), r)
         `CHK("rdata", mreg[i], d)
      end
      @(negedge i_clock);
      for (int s = 0; s < 8; s++) begin
         `CHK("field", field_of(s), fo_bus[7*s +: 7])
      end
   endtask

   task automatic accept_run(input int n, input bit rnd);
      for (int k = 0; k <= n; k++) begin
         @(posedge i_clock);
         i_accept <= (k < n);
         i_accept_src <= rnd ? 3'($urandom) : 3'(k);
         if (rnd && k < n && $urandom_range(1, 0) == 1) begin
            @(posedge i_clock);
            i_accept <= 1'b0;
         end
      end
      repeat (2) @(posedge i_clock);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_standby, i_accept} = '0;
      {i_awaddr, i_araddr, i_wdata, i_wstrb, i_accept_src} = '0;
      foreach (mreg[i]) mreg[i] = '0;
      void'($urandom(32'hbdb5));
      repeat (5) @(posedge i_clock);
      i_rstn <= 1'b1;
      check_all();
      repeat (3) begin
         for (int i = 0; i < 4; i++) reg_write(i, $urandom & 32'hffff7f7f, 4'($urandom));
         check_all();
      end
      for (int i = 0; i < 4; i++) reg_write(i, 32'h00007f7f, 4'hf);
      check_all();
      for (int i = 0; i < 4; i++) reg_write(i, 32'h0, 4'h2);
      check_all();
      // Unmapped and unaligned places must refuse and leave every register alone.
      axw(8'h20, 32'h00001111, 4'hf, r);
      `CHK("bresp_unmapped", 2'(SVN_AXI_SLVERR), r)
      axw(8'h02, 32'h00002222, 4'hf, r);
      `CHK("bresp_unaligned", 2'(SVN_AXI_SLVERR), r)
      axr(8'h40, d, r);
      `CHK("rresp_unmapped", 2'(SVN_AXI_SLVERR), r)
      `CHK("rdata_unmapped", 32'h0, d)
      check_all();
      for (int i = 0; i < 4; i++) reg_write(i, $urandom & 32'h00007f7f, 4'h3);
      i_standby <= 1'b1;
      repeat (6) @(posedge i_clock);
      check_all();
      i_standby <= 1'b0;
      repeat (3) @(posedge i_clock);
      check_all();
      reg_write(4, $urandom, 4'hf);
      accept_run(8, 1'b0);
      reg_write(4, 32'hffff_fff0, 4'hf);
      for (int i = 0; i < 4; i++) reg_write(i, $urandom & 32'h00007f7f, 4'h3);
      accept_run(16, 1'b1);
      check_all();
      // A second reset in mid-run must clear what was programmed.
      @(posedge i_clock);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rstn <= 1'b1;
      foreach (mreg[i]) mreg[i] = '0;
      check_all();
      accept_run(8, 1'b0);
      final_report();
   end
endmodule
